// ===== ldfs_partner.sv
// behavioural comparators and power switch around the sequencer
`timescale 1ns/1ns
module ldfs_partner (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // from the block
    input wire logic gate_drive,
    // scenario controls
    input wire logic [3:0] on_len,
    input wire logic [1:0] hit,
    input wire logic aux_on,
    // comparator outputs
    output logic sense_ov,
    output logic winding_diode_short_protect,
    output logic aux_above_short,
    output logic valley_detect,
    output logic setpoint_reached
);
    // ****************************************
    // switch phase tracking
    // ****************************************
    logic gate_q;
    logic [7:0] cnt;
    // phase counter restarts on every gate edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate_q <= 1'b0;
            cnt <= 8'h00;
        end else begin
            gate_q <= gate_drive;
            cnt <= (gate_drive != gate_q) ? 8'h00 : cnt + 8'h01;
        end
    end
    // on_len of zero never ends the on-time: only the limit can
    assign setpoint_reached = gate_q && on_len != 4'h0 && cnt >= {4'h0, on_len};
    assign winding_diode_short_protect = gate_q && hit[1] && cnt == 8'h03;
    assign sense_ov = !gate_q && hit[0] && cnt == 8'h01;
    assign aux_above_short = !gate_q && aux_on && cnt == 8'h01;
    // valleys ring every four cycles while the switch is off
    assign valley_detect = !gate_q && cnt[1:0] == 2'h3;
endmodule // ldfs_partner

// ===== ldfs_pkg.sv
// constants and types for the led driver fault sequencer
package ldfs_pkg;
    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_MHZ = 100;
    localparam int SHORT_DETECT_TIME_MS = 90;
    localparam int RECOVERY_TIME_S = 4;
    localparam int LINE_RANGE_BLANK_TIME_MS = 25;
    localparam int LEADING_EDGE_BLANK_TIME_NS = 175;
    localparam int SHORT_DETECT_CYC = SHORT_DETECT_TIME_MS * 1000 * CLK_MHZ;
    localparam int RECOVERY_CYC = RECOVERY_TIME_S * 1000000 * CLK_MHZ;
    localparam int LINE_BLANK_CYC = LINE_RANGE_BLANK_TIME_MS * 1000 * CLK_MHZ;
    localparam int LEB_CYC = (LEADING_EDGE_BLANK_TIME_NS * CLK_MHZ + 999) / 1000;
    // ****************************************
    // counts
    // ****************************************
    localparam logic [2:0] FAULT_CYCLES = 3'h4;
    localparam int CNT_W = 32;
    // ****************************************
    // apb map
    // ****************************************
    localparam logic [11:0] ADDR_STATUS = 12'h000;
    localparam logic [11:0] ADDR_MASK = 12'h004;
    localparam logic [11:0] ADDR_STATE = 12'h008;
    localparam int ST_SENSE_OV = 0;
    localparam int ST_SUPPLY_OV = 1;
    localparam int ST_WINDING = 2;
    localparam int ST_AUX = 3;
    localparam int ST_ILIM = 4;
    localparam int ST_BROWN = 5;
    localparam int EV_W = 6;
    localparam logic [5:0] MASK_RESET = 6'h00;
    typedef enum logic [2:0] {
        LDFS_OFF, LDFS_WAIT_VALLEY, LDFS_ON, LDFS_DEMAG, LDFS_PAUSE
    } ldfs_state_t;
endpackage

// ===== ldfs_top.sv
// led driver fault sequencer: switching control, protections, apb regs
`timescale 1ns/1ns
// Notes on behaviour
// - sense pin overvoltage in demag for four cycles in a row starts the pause.
// - programmable or supply overvoltage stops switching for the 4 s pause.
// - peak current limit in on-time drops gate drive at once.
// - winding/diode short comparator in four cycles in a row starts the pause.
// - no aux pulse above threshold for 90 ms flags a fault and a 4 s pause.
// - the 90 ms counter restarts on each aux pulse and is held clear in off and pause.
// - the compensation pin is grounded for the whole pause.
// - compensation is grounded during brown-out, lockout or thermal shutdown.
// - pulsing begins only after the brown-out rising comparator reports ok.
// - the brown-out falling comparator stops switching and shuts down.
// - a change to low line range is qualified by a 25 ms blanking interval.
// - high line sets at once; low line only after 25 ms below threshold.
// - low line starts on valley one; high line skips one, starts on two.
// - in high line the current control gain is halved.
// - the feed-forward current source is on only while gate drive is high.
// - the sense pin is grounded for the blanking time at gate turn-on.
module ldfs_top
    import ldfs_pkg::*;
#(
    parameter int SHORT_CYC = SHORT_DETECT_CYC,
    parameter int RECOV_CYC = RECOVERY_CYC,
    parameter int BLANK_CYC = LINE_BLANK_CYC
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // comparators
    input wire logic sense_ov,
    input wire logic supply_ov,
    input wire logic peak_current_limit,
    input wire logic winding_diode_short_protect,
    input wire logic aux_above_short,
    input wire logic brown_out_rise_ok,
    input wire logic brown_out_fall,
    input wire logic undervoltage_lockout,
    input wire logic thermal_shutdown,
    input wire logic line_above_high,
    input wire logic line_below_low,
    input wire logic valley_detect,
    input wire logic setpoint_reached,
    // power stage
    output logic gate_drive,
    output logic loop_comp_ground,
    output logic feed_forward_en,
    output logic sense_pin_ground,
    output logic high_line_flag,
    output logic gain_half,
    output logic irq
);
    // ****************************************
    // state
    // ****************************************
    ldfs_state_t state;
    logic [2:0] ov_cnt;
    logic [2:0] wd_cnt;
    logic ov_seen;
    logic wd_seen;
    logic [CNT_W-1:0] short_cnt;
    logic [CNT_W-1:0] pause_cnt;
    logic [CNT_W-1:0] blank_cnt;
    logic [7:0] leb_cnt;
    logic valley_skip;
    logic [EV_W-1:0] status;
    logic [EV_W-1:0] mask;
    logic [EV_W-1:0] ev;
    logic enabled;
    logic hold_off;
    logic ov_trip;
    logic wd_trip;
    logic aux_trip;
    logic open_trip;
    logic major;
    logic end_cycle;

    function automatic logic [2:0] bump(input logic [2:0] c);
        bump = (c == FAULT_CYCLES) ? c : c + 3'h1;
    endfunction

    // condition blocking any pulsing
    assign hold_off = brown_out_fall | undervoltage_lockout | thermal_shutdown;
    assign end_cycle = (state == LDFS_DEMAG) && valley_detect;
    assign ov_trip = end_cycle && (bump(ov_cnt) == FAULT_CYCLES) && ov_seen;
    assign wd_trip = end_cycle && (bump(wd_cnt) == FAULT_CYCLES) && wd_seen;
    assign aux_trip = (state != LDFS_OFF) && (state != LDFS_PAUSE)
        && (short_cnt >= SHORT_CYC[CNT_W-1:0] - 32'h1) && !aux_above_short;
    assign open_trip = supply_ov && (state != LDFS_OFF)
        && (state != LDFS_PAUSE);
    assign major = ov_trip | wd_trip | aux_trip | open_trip;

    // ****************************************
    // enable latch after brown-out clear
    // ****************************************
    // pulsing waits for the rising level, falling level drops it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enabled <= 1'b0;
        end else if (hold_off) begin
            enabled <= 1'b0;
        end else if (brown_out_rise_ok) begin
            enabled <= 1'b1;
        end
    end

    // ****************************************
    // switching sequencer
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= LDFS_OFF;
        end else if (hold_off || !enabled) begin
            state <= LDFS_OFF;
        end else if (major) begin
            state <= LDFS_PAUSE;
        end else begin
            case (state)
                LDFS_OFF: state <= LDFS_ON;
                LDFS_WAIT_VALLEY: begin
                    // high line skips the first valley
                    if (valley_detect && (!high_line_flag || valley_skip)) begin
                        state <= LDFS_ON;
                    end
                end
                LDFS_ON: begin
                    if (peak_current_limit) begin
                        state <= LDFS_DEMAG;
                    end else if (setpoint_reached && leb_cnt == 8'h00) begin
                        state <= LDFS_DEMAG;
                    end
                end
                LDFS_DEMAG: begin
                    if (valley_detect) begin
                        state <= high_line_flag ? LDFS_WAIT_VALLEY : LDFS_ON;
                    end
                end
                LDFS_PAUSE: begin
                    if (pause_cnt >= RECOV_CYC[CNT_W-1:0] - 32'h1) begin
                        state <= LDFS_OFF;
                    end
                end
                default: state <= LDFS_OFF;
            endcase
        end
    end

    // remembers that valley one went by at the end of demagnetisation, so
    // the wait state starts on the very next valley (valley two)
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            valley_skip <= 1'b0;
        end else if (state == LDFS_DEMAG && valley_detect) begin
            valley_skip <= 1'b1;
        end else if (state == LDFS_ON) begin
            valley_skip <= 1'b0;
        end
    end

    // ****************************************
    // consecutive cycle counters
    // ****************************************
    // flags collect a sense hit anywhere in demag and a winding hit anywhere in on-time
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ov_seen <= 1'b0;
            wd_seen <= 1'b0;
        end else if (end_cycle || state == LDFS_PAUSE) begin
            ov_seen <= 1'b0;
            wd_seen <= 1'b0;
        end else begin
            if (state == LDFS_DEMAG && sense_ov) begin
                ov_seen <= 1'b1;
            end
            if (state == LDFS_ON && winding_diode_short_protect) begin
                wd_seen <= 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ov_cnt <= 3'h0;
            wd_cnt <= 3'h0;
        end else if (state == LDFS_PAUSE || state == LDFS_OFF) begin
            ov_cnt <= 3'h0;
            wd_cnt <= 3'h0;
        end else if (end_cycle) begin
            ov_cnt <= ov_seen ? bump(ov_cnt) : 3'h0;
            wd_cnt <= wd_seen ? bump(wd_cnt) : 3'h0;
        end
    end

    // ****************************************
    // timers
    // ****************************************
    // aux short timer only runs while operating
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            short_cnt <= '0;
        end else if (aux_above_short || state == LDFS_OFF
                     || state == LDFS_PAUSE) begin
            short_cnt <= '0;
        end else begin
            short_cnt <= short_cnt + 32'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pause_cnt <= '0;
        end else if (state == LDFS_PAUSE) begin
            pause_cnt <= pause_cnt + 32'h1;
        end else begin
            pause_cnt <= '0;
        end
    end

    // line range: set at once, clear after a long stay below low threshold
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            high_line_flag <= 1'b0;
            blank_cnt <= '0;
        end else if (line_above_high) begin
            high_line_flag <= 1'b1;
            blank_cnt <= '0;
        end else if (!line_below_low) begin
            blank_cnt <= '0;
        end else if (blank_cnt >= BLANK_CYC[CNT_W-1:0]) begin
            high_line_flag <= 1'b0;
        end else begin
            blank_cnt <= blank_cnt + 32'h1;
        end
    end

    // leading edge blanking counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            leb_cnt <= 8'h00;
        end else if (state != LDFS_ON) begin
            leb_cnt <= LEB_CYC[7:0];
        end else if (leb_cnt != 8'h00) begin
            leb_cnt <= leb_cnt - 8'h01;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    // gate drops in the same edge the limit trips, outputs stay registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate_drive <= 1'b0;
            feed_forward_en <= 1'b0;
            sense_pin_ground <= 1'b0;
            loop_comp_ground <= 1'b1;
            gain_half <= 1'b0;
        end else begin
            gate_drive <= (state == LDFS_ON) && !peak_current_limit
                && !major && !hold_off;
            feed_forward_en <= (state == LDFS_ON) && !peak_current_limit
                && !major && !hold_off;
            sense_pin_ground <= (state == LDFS_ON) && leb_cnt > 8'h01;
            loop_comp_ground <= (state == LDFS_PAUSE) || major
                || hold_off || !enabled;
            gain_half <= high_line_flag;
        end
    end

    // ****************************************
    // apb registers and interrupt
    // ****************************************
    assign ev = {hold_off & enabled, peak_current_limit & (state == LDFS_ON),
                 aux_trip, wd_trip, open_trip, ov_trip};

    // set wins over write-one-to-clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status <= '0;
            mask <= MASK_RESET;
        end else begin
            if (psel && penable && pwrite && paddr == ADDR_STATUS) begin
                status <= (status & ~pwdata[EV_W-1:0]) | ev;
            end else begin
                status <= status | ev;
            end
            if (psel && penable && pwrite && paddr == ADDR_MASK) begin
                mask <= pwdata[EV_W-1:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
            irq <= 1'b0;
        end else begin
            irq <= |(status & mask);
            pready <= psel && !penable;
            pslverr <= psel && !penable && paddr != ADDR_STATUS
                && paddr != ADDR_MASK && paddr != ADDR_STATE;
            case (paddr)
                ADDR_STATUS: prdata <= {26'h0, status};
                ADDR_MASK: prdata <= {26'h0, mask};
                ADDR_STATE: prdata <= {26'h0, high_line_flag, enabled,
                                       1'b0, state};
                default: prdata <= 32'h0;
            endcase
        end
    end

    // ****************************************
    // checks
    // ****************************************
    chk_limit_cuts_gate: assert property (@(posedge pclk) disable iff (!presetn)
        peak_current_limit |=> !gate_drive)
        else $error("gate high after current limit");
    chk_pause_grounds_comp: assert property (@(posedge pclk)
        disable iff (!presetn)
        state == LDFS_PAUSE |=> loop_comp_ground)
        else $error("comp not grounded in pause");
    chk_hold_grounds_comp: assert property (@(posedge pclk)
        disable iff (!presetn)
        hold_off |=> loop_comp_ground && !gate_drive)
        else $error("comp free during hold off");
    chk_ff_follows_gate: assert property (@(posedge pclk)
        disable iff (!presetn) feed_forward_en == gate_drive)
        else $error("feed forward not tied to gate");
    chk_ov_enters_pause: assert property (@(posedge pclk)
        disable iff (!presetn)
        ov_trip && !hold_off && enabled |=> state == LDFS_PAUSE)
        else $error("ov trip missed");
    chk_open_enters_pause: assert property (@(posedge pclk)
        disable iff (!presetn)
        open_trip && !hold_off && enabled |=> state == LDFS_PAUSE)
        else $error("open trip missed");
    chk_high_line_set: assert property (@(posedge pclk)
        disable iff (!presetn) line_above_high |=> high_line_flag)
        else $error("high line not set");
    chk_gain_half_line: assert property (@(posedge pclk)
        disable iff (!presetn) high_line_flag |=> gain_half)
        else $error("gain not halved");
    chk_brown_stops: assert property (@(posedge pclk)
        disable iff (!presetn) brown_out_fall |=> state == LDFS_OFF)
        else $error("brown out ignored");
    chk_leb_ground: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(gate_drive) |-> sense_pin_ground)
        else $error("no blanking at turn on");
endmodule // ldfs_top

// ===== testbench.sv
// self-checking testbench for the led driver fault sequencer
`timescale 1ns/1ns
module testbench;
    import ldfs_pkg::*;
    // ****************************************
    // bench
    // ****************************************
    localparam int SC = 50;
    localparam int RC = 200;
    localparam int BC = 30;
    localparam int SBIT [4] = '{ST_SENSE_OV, ST_WINDING, ST_SUPPLY_OV, ST_AUX};
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, gate_p;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic sense_ov, supply_ov, peak_current_limit, aux_above_short;
    logic winding_diode_short_protect, brown_out_rise_ok, brown_out_fall;
    logic undervoltage_lockout, thermal_shutdown, line_above_high;
    logic line_below_low, valley_detect, setpoint_reached, gate_drive;
    logic loop_comp_ground, feed_forward_en, sense_pin_ground;
    logic high_line_flag, gain_half, irq, aux_on;
    logic [3:0] on_len;
    logic [1:0] hit;
    int errors, checks_done, n, last_v, vcnt, hi_n;
    ldfs_top #(.SHORT_CYC(SC), .RECOV_CYC(RC), .BLANK_CYC(BC)) dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .sense_ov, .supply_ov, .peak_current_limit,
        .winding_diode_short_protect, .aux_above_short, .brown_out_rise_ok,
        .brown_out_fall, .undervoltage_lockout, .thermal_shutdown,
        .line_above_high, .line_below_low, .valley_detect, .setpoint_reached,
        .gate_drive, .loop_comp_ground, .feed_forward_en, .sense_pin_ground,
        .high_line_flag, .gain_half, .irq);
    ldfs_partner model (.pclk, .presetn, .gate_drive, .on_len, .hit, .aux_on,
        .sense_ov, .winding_diode_short_protect, .aux_above_short,
        .valley_detect, .setpoint_reached);
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask
    // one apb transfer; waits on pready, never on a fixed count
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // only the watchdog ends a wait that never sees pready
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wait_gate(input logic v, input int lim);
        n = 0;
        while (gate_drive !== v && n < lim) begin
            @(posedge pclk);
            n++;
        end
        chk(32'(gate_drive), 32'(v), "gate drive wait");
    endtask
    // one more edge lets the valley monitor record the turn-on first
    task cycle();
        wait_gate(1'b0, 40);
        wait_gate(1'b1, 40);
        @(posedge pclk);
    endtask
    task wait_state(input logic [2:0] e);
        int k;
        k = 0;
        do begin
            apb(1'b0, ADDR_STATE, 32'h0);
            k++;
        end while (rd[2:0] !== e && k < 60);
        chk(32'(rd[2:0]), 32'(e), "state");
    endtask
    // re-arm the start comparator; a hold-off leaves the block disabled
    task restart();
        brown_out_rise_ok <= 1'b0;
        repeat (2) @(posedge pclk);
        brown_out_rise_ok <= 1'b1;
        wait_gate(1'b1, 300);
    endtask
    task recover(input int b);
        int bad;
        bad = 0;
        repeat (RC - 40) begin
            @(posedge pclk);
            if (loop_comp_ground !== 1'b1 || gate_drive !== 1'b0) bad++;
        end
        chk(bad, 0, "pause hold");
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(32'(rd[b]), 32'h1, "trip flag");
        apb(1'b1, ADDR_STATUS, 32'h1 << b);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(32'(rd[b]), 32'h0, "flag clear");
        restart();
    endtask
    task print_verdict();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // valley count per off-time, blanking and feed-forward watch
    always @(posedge pclk) begin
        gate_p <= gate_drive;
        hi_n = gate_drive ? hi_n + 1 : 0;
        if (gate_p && !gate_drive) vcnt = 0;
        else if (!gate_drive && valley_detect) vcnt++;
        if (!gate_p && gate_drive) last_v = vcnt;
        if (hi_n == 2) chk(32'(sense_pin_ground), 32'h1, "blank");
        if (presetn) chk(32'(feed_forward_en), 32'(gate_drive), "ff");
    end
    initial begin
        repeat (50000) @(posedge pclk);
        errors++;
        print_verdict();
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
        {sense_ov, supply_ov, peak_current_limit, brown_out_rise_ok} = '0;
        {brown_out_fall, undervoltage_lockout, thermal_shutdown} = '0;
        {line_above_high, line_below_low, hit, gate_p} = '0;
        {errors, checks_done, vcnt, last_v, hi_n} = '0;
        on_len = 4'h6;
        aux_on = 1'b1;
        repeat (20) @(posedge pclk);
        chk(32'(loop_comp_ground), 32'h1, "reset comp");
        presetn <= 1'b1;
        repeat (30) @(posedge pclk);
        chk(32'(gate_drive), 32'h0, "no early pulse");
        apb(1'b0, ADDR_MASK, 32'h0);
        chk(rd, 32'(MASK_RESET), "mask reset");
        apb(1'b0, 12'h010, 32'h0);
        chk({rd[30:0], er}, 32'h1, "unmapped");
        brown_out_rise_ok <= 1'b1;
        wait_gate(1'b1, 20);
        cycle();
        cycle();
        chk(last_v, 1, "first valley");
        // current limit ends the pulse and raises the unmasked interrupt
        apb(1'b1, ADDR_MASK, 32'h10);
        on_len <= 4'h0;
        wait_gate(1'b1, 40);
        repeat (3) @(posedge pclk);
        peak_current_limit <= 1'b1;
        wait_gate(1'b0, 2);
        peak_current_limit <= 1'b0;
        on_len <= 4'h6;
        repeat (3) @(posedge pclk);
        chk(32'(irq), 32'h1, "irq set");
        apb(1'b1, ADDR_STATUS, 32'h10);
        repeat (3) @(posedge pclk);
        chk(32'(irq), 32'h0, "irq clear");
        // line range: immediate rise, blanked fall
        line_above_high <= 1'b1;
        repeat (2) @(posedge pclk);
        chk(32'(high_line_flag), 32'h1, "line high");
        @(posedge pclk);
        chk(32'(gain_half), 32'h1, "gain half");
        cycle();
        cycle();
        chk(last_v, 2, "second valley");
        line_above_high <= 1'b0;
        line_below_low <= 1'b1;
        repeat (BC - 5) @(posedge pclk);
        chk(32'(high_line_flag), 32'h1, "blanked");
        repeat (15) @(posedge pclk);
        chk(32'(high_line_flag), 32'h0, "line low");
        chk(32'(gain_half), 32'h0, "gain full");
        cycle();
        cycle();
        chk(last_v, 1, "low valley");
        // faults that force the pause; counted ones broken once first
        for (int f = 0; f < 4; f++) begin
            wait_gate(1'b1, 40);
            if (f < 2) begin
                hit <= 2'(1 << f);
                repeat (3) cycle();
                hit <= 2'h0;
                cycle();
                hit <= 2'(1 << f);
                repeat (3) cycle();
                apb(1'b0, ADDR_STATUS, 32'h0);
                chk(32'(rd[2:0] & 3'h5), 32'h0, "early trip");
            end else if (f == 2) begin
                supply_ov <= 1'b1;
                @(posedge pclk);
                supply_ov <= 1'b0;
            end else aux_on <= 1'b0;
            wait_state(3'h4);
            hit <= 2'h0;
            aux_on <= 1'b1;
            recover(SBIT[f]);
        end
        // brown-out fall, lockout and thermal stop ground the compensation
        for (int s = 0; s < 3; s++) begin
            {brown_out_fall, undervoltage_lockout, thermal_shutdown} <= 3'(4 >> s);
            repeat (4) @(posedge pclk);
            chk(32'(loop_comp_ground), 32'h1, "comp ground");
            if (s == 0) chk(32'(gate_drive), 32'h0, "shut down");
            {brown_out_fall, undervoltage_lockout, thermal_shutdown} <= 3'h0;
            restart();
        end
        print_verdict();
    end
endmodule // testbench
